/* hw/move_instruction_decode.sv */
// decoder and timing for debug/test register moves, string copy, extending moves
`timescale 1ns/100ps
`default_nettype none
module move_instruction_decode
	import move_decode_pkg::*;
(
	input  wire logic        clk,          // 25 MHz core clock
	input  wire logic        reset_n,      // async reset, active low
	input  wire logic [7:0]  fetch_byte,   // instruction byte from front end
	input  wire logic        fetch_valid,  // fetch_byte is valid
	input  wire logic        operand_32,   // current operand size is 32 bits
	input  wire logic        cache_miss,   // operand access missed, sampled at decode end
	output logic             fetch_ready,  // decoder can take a byte
	output decoded_op_t      op,           // decoded operation
	output logic             op_valid,     // pulse: op decoded, execution starts
	output logic [7:0]       op_clocks,    // clocks charged for op
	output logic             op_done,      // pulse: execution finished
	output logic             op_invalid    // pulse: unsupported encoding
);
	// decoder phases
	typedef enum logic [1:0] {
		PH_FIRST,   // expecting first opcode byte
		PH_SECOND,  // after escape byte
		PH_MODRM,   // expecting operand byte
		PH_EXEC     // waiting for execution count
	} phase_t;

	// whole decoder state
	typedef struct packed {
		phase_t      phase;    // current phase
		logic [7:0]  opcode;   // second opcode byte
		decoded_op_t op;       // result
		logic        valid;    // op_valid pulse
		logic [7:0]  clocks;   // charged clocks
		logic        invalid;  // op_invalid pulse
		logic        done;     // op_done pulse, counter end one clock late
		logic        ready;    // fetch_ready
	} dec_state_t;

	dec_state_t state;      // registered state
	dec_state_t next_state; // next value
	logic       exec_busy;  // counter running
	logic       exec_done;  // counter end pulse

	// size of full operand for current mode
	function automatic op_size_t full_size(input logic wide);
		full_size = wide ? SIZE_DWORD : SIZE_WORD;
	endfunction : full_size

	// cost of the decoded op including any miss penalty
	function automatic logic [7:0] op_cost(input decoded_op_t d, input logic miss);
		logic [7:0] base;
		logic       mem;
		base = CLK_ZERO;
		mem  = 1'b0;
		case (d.kind)
			OPK_DEBUG_WRITE: base = CLK_DEBUG_WRITE;
			OPK_DEBUG_READ:  base = CLK_DEBUG_READ;
			OPK_TEST_WRITE:  base = CLK_TEST_MOVE;
			OPK_TEST_READ:   base = CLK_TEST_MOVE;
			OPK_STRING_COPY: begin
				base = CLK_STRING_COPY;
				mem  = 1'b1;
			end
			OPK_SIGN_EXTEND: begin
				base = d.mem_source ? CLK_EXTEND_MEM : CLK_SIGN_REG;
				mem  = d.mem_source;
			end
			OPK_ZERO_EXTEND: begin
				base = CLK_ZERO_EXTEND;
				mem  = d.mem_source;
			end
			default: base = CLK_ZERO;
		endcase
		op_cost = (mem && miss) ? base + CLK_MISS_PENALTY : base;
	endfunction : op_cost

	// decode sequence
	always_comb begin
		next_state         = state;
		next_state.valid   = 1'b0;
		next_state.invalid = 1'b0;
		next_state.done    = exec_done; // end pulse goes out one clock after the counter
		case (state.phase)
			// first byte: escape or single-byte string copy
			PH_FIRST: begin
				next_state.ready = 1'b1;
				if (fetch_valid && state.ready) begin
					next_state.op = '0;
					if (fetch_byte == ESCAPE_BYTE) begin
						next_state.phase = PH_SECOND;
					end else if (fetch_byte[7:1] == OP_STRING_COPY) begin
						next_state.op.kind       = OPK_STRING_COPY;
						next_state.op.mem_source = 1'b1;
						next_state.op.src_size   = fetch_byte[0] ?
							full_size(operand_32) : SIZE_BYTE;
						next_state.op.dst_size   = next_state.op.src_size;
						next_state.phase         = PH_EXEC;
						next_state.ready         = 1'b0;
					end else begin
						next_state.invalid = 1'b1; // not in this slice
					end
				end
			end
			// second byte picks the operation kind
			PH_SECOND: begin
				if (fetch_valid) begin
					next_state.opcode = fetch_byte;
					next_state.phase  = PH_MODRM;
					if (fetch_byte == OP_DEBUG_WRITE) begin
						next_state.op.kind = OPK_DEBUG_WRITE;
					end else if (fetch_byte == OP_DEBUG_READ) begin
						next_state.op.kind = OPK_DEBUG_READ;
					end else if (fetch_byte == OP_TEST_WRITE) begin
						next_state.op.kind = OPK_TEST_WRITE;
					end else if (fetch_byte == OP_TEST_READ) begin
						next_state.op.kind = OPK_TEST_READ;
					end else if (fetch_byte[7:1] == OP_SIGN_EXTEND) begin
						next_state.op.kind = OPK_SIGN_EXTEND;
					end else if (fetch_byte[7:1] == OP_ZERO_EXTEND) begin
						next_state.op.kind = OPK_ZERO_EXTEND;
					end else begin
						next_state.invalid = 1'b1;
						next_state.phase   = PH_FIRST;
					end
				end
			end
			// operand byte: register fields, form and sizes
			PH_MODRM: begin
				if (fetch_valid) begin
					next_state.phase            = PH_EXEC;
					next_state.ready            = 1'b0;
					next_state.op.special_reg   = fetch_byte[5:3];
					next_state.op.gen_reg       = fetch_byte[5:3];
					next_state.op.rm_reg        = fetch_byte[2:0];
					next_state.op.src_size      = SIZE_DWORD;
					next_state.op.dst_size      = SIZE_DWORD;
					case (state.op.kind)
						OPK_DEBUG_WRITE, OPK_DEBUG_READ: begin
							next_state.op.gen_reg = fetch_byte[2:0];
							// eee 100 and 101 have no debug register
							if (fetch_byte[7:6] != MODE_REGISTER ||
								fetch_byte[5:4] == 2'h2) begin
								next_state.op.kind = OPK_INVALID;
							end
						end
						OPK_TEST_WRITE, OPK_TEST_READ: begin
							next_state.op.gen_reg = fetch_byte[2:0];
							if (fetch_byte[7:6] != MODE_REGISTER ||
								fetch_byte[5:3] < TEST_REG_LOWEST) begin
								next_state.op.kind = OPK_INVALID;
							end
						end
						default: begin // extending moves
							next_state.op.mem_source = fetch_byte[7:6] != MODE_REGISTER;
							next_state.op.dst_size   = full_size(operand_32);
							next_state.op.src_size   = state.opcode[0] ?
								SIZE_WORD : SIZE_BYTE;
						end
					endcase
				end
			end
			// charge, count, then reopen the fetch side
			PH_EXEC: begin
				if (state.op.kind == OPK_INVALID) begin
					// refused encoding: pulse and wait for a new first byte
					next_state.invalid = 1'b1;
					next_state.phase   = PH_FIRST;
					next_state.ready   = 1'b1;
				end else if (state.done) begin
					// end pulse is out: ready returns one clock after it
					next_state.phase = PH_FIRST;
					next_state.ready = 1'b1;
				end else if (!state.valid && !exec_busy && !exec_done) begin
					// first clock here: charge the op and start the count;
					// the end pulse guard stops a finished op being charged twice
					next_state.valid  = 1'b1;
					next_state.clocks = op_cost(state.op, cache_miss);
				end
			end
			default: next_state.phase = PH_FIRST;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// execution timing
	cycle_counter #(
		.WIDTH (8)
	) u_counter (
		.clk     (clk),
		.reset_n (reset_n),
		.load    (state.valid),
		.cost    (state.clocks),
		.busy    (exec_busy),
		.done    (exec_done)
	);

	assign fetch_ready = state.ready;
	assign op          = state.op;
	assign op_valid    = state.valid;
	assign op_clocks   = state.clocks;
	assign op_done     = state.done;
	assign op_invalid  = state.invalid;
endmodule : move_instruction_decode
`default_nettype wire

/* hw/move_decode_pkg.sv */
// shared constants and carriers for the move instruction decoder
package move_decode_pkg;
	localparam logic [7:0] ESCAPE_BYTE      = 8'h0F; // two-byte opcode escape
	localparam logic [7:0] OP_DEBUG_WRITE   = 8'h23; // general reg to debug reg
	localparam logic [7:0] OP_DEBUG_READ    = 8'h21; // debug reg to general reg
	localparam logic [7:0] OP_TEST_WRITE    = 8'h26; // general reg to test reg
	localparam logic [7:0] OP_TEST_READ     = 8'h24; // test reg to general reg
	localparam logic [6:0] OP_STRING_COPY   = 7'h52; // 1010010w
	localparam logic [6:0] OP_SIGN_EXTEND   = 7'h5F; // 1011111w
	localparam logic [6:0] OP_ZERO_EXTEND   = 7'h5B; // 1011011w
	localparam logic [1:0] MODE_REGISTER    = 2'h3;  // mod field of register form
	localparam logic [7:0] CLK_DEBUG_WRITE  = 8'h0A; // 10 clocks
	localparam logic [7:0] CLK_DEBUG_READ   = 8'h09; // 9 clocks
	localparam logic [7:0] CLK_TEST_MOVE    = 8'h04; // 4 clocks
	localparam logic [7:0] CLK_STRING_COPY  = 8'h07; // 7 clocks on hit
	localparam logic [7:0] CLK_SIGN_REG     = 8'h02; // 2 clocks
	localparam logic [7:0] CLK_EXTEND_MEM   = 8'h03; // 3 clocks
	localparam logic [7:0] CLK_ZERO_EXTEND  = 8'h03; // 3 clocks both forms
	localparam logic [7:0] CLK_MISS_PENALTY = 8'h02; // added on cache miss
	localparam logic [7:0] CLK_ZERO         = 8'h00; // idle count
	localparam logic [2:0] TEST_REG_LOWEST  = 3'h3;  // test regs 3..7 only

	// decoded operation kinds
	typedef enum logic [3:0] {
		OPK_NONE,
		OPK_DEBUG_WRITE,
		OPK_DEBUG_READ,
		OPK_TEST_WRITE,
		OPK_TEST_READ,
		OPK_STRING_COPY,
		OPK_SIGN_EXTEND,
		OPK_ZERO_EXTEND,
		OPK_INVALID
	} op_kind_t;

	// element / source size
	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_DWORD
	} op_size_t;

	// result handed to register file and memory path
	typedef struct packed {
		op_kind_t   kind;        // operation decoded
		op_size_t   src_size;    // source element size
		op_size_t   dst_size;    // destination size
		logic [2:0] special_reg; // debug or test register number
		logic [2:0] gen_reg;     // general register (reg / reg1)
		logic [2:0] rm_reg;      // r/m or reg2 field
		logic       mem_source;  // memory operand form
	} decoded_op_t;
endpackage : move_decode_pkg

/* hw/cycle_counter.sv */
// execution clock counter: loads a cost, counts down, pulses when done
`timescale 1ns/100ps
`default_nettype none
module cycle_counter
	import move_decode_pkg::*;
#(
	parameter int WIDTH = 8 // counter width
) (
	input  wire logic             clk,     // core clock
	input  wire logic             reset_n, // async reset, active low
	input  wire logic             load,    // start a new count
	input  wire logic [WIDTH-1:0] cost,    // clocks to spend, at least 1
	output var  logic             busy,    // counting
	output var  logic             done     // one-cycle pulse at end
);
	// whole state of the counter
	typedef struct packed {
		logic [WIDTH-1:0] remain; // clocks left
		logic             busy;   // running
		logic             done;   // end pulse
	} count_state_t;

	count_state_t state;      // registered state
	count_state_t next_state; // next value

	// next-state logic
	always_comb begin
		next_state      = state;
		next_state.done = 1'b0;
		if (load) begin
			next_state.remain = cost - WIDTH'(1);
			next_state.busy   = 1'b1;
			if (cost <= WIDTH'(1)) begin // single-clock cost finishes now
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
		end else if (state.busy) begin
			if (state.remain <= WIDTH'(1)) begin // last clock
				next_state.busy   = 1'b0;
				next_state.done   = 1'b1;
				next_state.remain = '0;
			end else begin
				next_state.remain = state.remain - WIDTH'(1);
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busy = state.busy;
	assign done = state.done;
endmodule : cycle_counter
`default_nettype wire

/* bench/move_decode_sva.sv */
// port timing checker for the move decoder
`timescale 1ns/100ps
`default_nettype none
module move_decode_sva
	import move_decode_pkg::*;
(
	input wire logic        clk,         // core clock
	input wire logic        reset_n,     // async reset
	input wire logic        cache_miss,  // miss level
	input wire logic        fetch_ready, // decoder ready
	input wire decoded_op_t op,          // decoded op
	input wire logic        op_valid,    // decode pulse
	input wire logic [7:0]  op_clocks,   // charged clocks
	input wire logic        op_done,     // end pulse
	input wire logic        op_invalid   // refusal pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] left; // clocks still to run
	// shadow count of the charged clocks
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n) left <= 8'h00;
		else if (op_valid) left <= op_clocks;
		else if (left != 8'h00) left <= left - 8'h01;
	debug_write_cost_a: assert property (op_valid && op.kind == OPK_DEBUG_WRITE |-> op_clocks == 8'h0A)
		else $error("debug write charge wrong");
	debug_reg_sel_a: assert property (op_valid && op.kind inside {OPK_DEBUG_WRITE, OPK_DEBUG_READ}
		|-> !(op.special_reg inside {3'h4, 3'h5})) else $error("debug reg out of map");
	debug_read_cost_a: assert property (op_valid && op.kind == OPK_DEBUG_READ |-> op_clocks == 8'h09)
		else $error("debug read charge wrong");
	test_write_cost_a: assert property (op_valid && op.kind == OPK_TEST_WRITE
		|-> op_clocks == 8'h04 && op.special_reg >= 3'h3) else $error("test write wrong");
	test_read_cost_a: assert property (op_valid && op.kind == OPK_TEST_READ |-> op_clocks == 8'h04)
		else $error("test read charge wrong");
	copy_cost_a: assert property (op_valid && op.kind == OPK_STRING_COPY
		|-> op_clocks == ($past(cache_miss) ? 8'h09 : 8'h07)) else $error("copy charge wrong");
	copy_size_a: assert property (op_valid && op.kind == OPK_STRING_COPY
		|-> op.src_size == op.dst_size) else $error("copy sizes differ");
	sign_cost_a: assert property (op_valid && op.kind == OPK_SIGN_EXTEND |-> op_clocks ==
		(op.mem_source ? ($past(cache_miss) ? 8'h05 : 8'h03) : 8'h02)) else $error("sign charge");
	zero_cost_a: assert property (op_valid && op.kind == OPK_ZERO_EXTEND |-> op_clocks ==
		((op.mem_source && $past(cache_miss)) ? 8'h05 : 8'h03)) else $error("zero charge");
	done_due_a: assert property (left == 8'h01 |=> op_done)
		else $error("done pulse missing");
	done_cause_a: assert property (op_done |-> $past(left) == 8'h01 && !fetch_ready)
		else $error("done pulse early");
	cover property (op_done);
	cover property (op_invalid);
	cover property (op_valid && op.kind == OPK_STRING_COPY && op_clocks == 8'h09);
endmodule : move_decode_sva
bind move_instruction_decode move_decode_sva i_move_decode_sva (.clk(clk), .reset_n(reset_n),
	.cache_miss(cache_miss), .fetch_ready(fetch_ready), .op(op), .op_valid(op_valid),
	.op_clocks(op_clocks), .op_done(op_done), .op_invalid(op_invalid));
`default_nettype wire

/* bench/fetch_model.sv */
// instruction byte front end model
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
	input  wire logic       clk,         // core clock
	input  wire logic       fetch_ready, // decoder ready
	output var  logic [7:0] fetch_byte,  // byte offered
	output var  logic       fetch_valid  // byte valid
);
	initial begin
		fetch_byte  = 8'h00;
		fetch_valid = 1'b0;
	end
	// offer n bytes one per edge once ready
	task automatic send(input logic [7:0] b [3], input int n);
		int w;
		w = 0;
		@(negedge clk);
		while (fetch_ready !== 1'b1 && w < 100) begin
			w++;
			@(negedge clk);
		end
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			fetch_valid <= 1'b1;
			fetch_byte  <= b[i];
		end
		@(posedge clk);
		fetch_valid <= 1'b0;
		fetch_byte  <= ~b[n-1]; // released: no stale byte
	endtask : send
endmodule : fetch_model
`default_nettype wire

/* bench/move_instruction_decode_test.sv */
// self-checking bench for the move decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module move_instruction_decode_test
	import move_decode_pkg::*;
;
	logic        clk, reset_n, operand_32, cache_miss;  // drive side
	logic        fetch_ready, fetch_valid, op_valid, op_done, op_invalid; // handshakes
	logic [7:0]  fetch_byte, op_clocks;                 // byte and charge
	decoded_op_t op;                                    // decoded result
	int          bad_count, checks_done, cycles;        // tallies
	move_instruction_decode i_move_instruction_decode (.clk(clk), .reset_n(reset_n),
		.fetch_byte(fetch_byte), .fetch_valid(fetch_valid), .operand_32(operand_32),
		.cache_miss(cache_miss), .fetch_ready(fetch_ready), .op(op), .op_valid(op_valid),
		.op_clocks(op_clocks), .op_done(op_done), .op_invalid(op_invalid));
	fetch_model i_fetch_model (.clk(clk), .fetch_ready(fetch_ready), .fetch_byte(fetch_byte),
		.fetch_valid(fetch_valid));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done;
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// one op: send bytes, judge kind, charge and done spacing
	task automatic run_op(input logic [7:0] b [3], input int n, input logic o32, miss,
		input op_kind_t k, input logic [7:0] c);
		int w;
		w = 0;
		@(posedge clk);
		operand_32 <= o32;
		cache_miss <= miss;
		i_fetch_model.send(b, n);
		@(negedge clk);
		while (op_valid !== 1'b1 && op_invalid !== 1'b1 && w < 50) begin
			w++;
			@(negedge clk);
		end
		if (k == OPK_INVALID) begin
			`CHK("refused", 1'b1, op_invalid)
			`CHK("no op", 1'b0, op_valid)
		end else begin
			`CHK("kind", k, op.kind)
			`CHK("clocks", c, op_clocks)
			w = 0;
			@(negedge clk);
			while (op_done !== 1'b1 && w < 300) begin
				w++;
				@(negedge clk);
			end
			`CHK("done gap", int'(c), w)
			`CHK("ready held", 1'b0, fetch_ready)
			@(negedge clk);
			`CHK("ready back", 1'b1, fetch_ready)
		end
	endtask : run_op
	// debug moves, every eee, plus memory form
	task automatic t_debug;
		logic bad;
		for (int e = 0; e < 8; e++) begin
			bad = (e == 4 || e == 5);
			run_op('{8'h0F, 8'h23, {2'b11, e[2:0], 3'h2}}, 3, 1'b1, 1'b0,
				bad ? OPK_INVALID : OPK_DEBUG_WRITE, 8'h0A);
			if (!bad) `CHK("dbg reg", e[2:0], op.special_reg)
			if (!bad) `CHK("dbg gen", 3'h2, op.gen_reg)
			run_op('{8'h0F, 8'h21, {2'b11, e[2:0], 3'h5}}, 3, 1'b0, 1'b1,
				bad ? OPK_INVALID : OPK_DEBUG_READ, 8'h09);
			if (!bad) `CHK("dbg reg", e[2:0], op.special_reg)
			if (!bad) `CHK("dbg gen", 3'h5, op.gen_reg)
		end
		run_op('{8'h0F, 8'h23, 8'h02}, 3, 1'b1, 1'b0, OPK_INVALID, 8'h00);
	endtask : t_debug
	// test moves, every eee
	task automatic t_test;
		logic bad;
		for (int e = 0; e < 8; e++) begin
			bad = (e < 3);
			run_op('{8'h0F, 8'h26, {2'b11, e[2:0], 3'h1}}, 3, 1'b1, 1'b1,
				bad ? OPK_INVALID : OPK_TEST_WRITE, 8'h04);
			if (!bad) `CHK("test reg", e[2:0], op.special_reg)
			if (!bad) `CHK("test gen", 3'h1, op.gen_reg)
			run_op('{8'h0F, 8'h24, {2'b11, e[2:0], 3'h6}}, 3, 1'b0, 1'b0,
				bad ? OPK_INVALID : OPK_TEST_READ, 8'h04);
			if (!bad) `CHK("test reg", e[2:0], op.special_reg)
			if (!bad) `CHK("test gen", 3'h6, op.gen_reg)
		end
	endtask : t_test
	// string copy over w, operand size and miss
	task automatic t_string;
		op_size_t sz;
		for (int i = 0; i < 8; i++) begin
			sz = !i[0] ? SIZE_BYTE : (i[1] ? SIZE_DWORD : SIZE_WORD);
			run_op('{{7'h52, i[0]}, 8'h00, 8'h00}, 1, i[1], i[2], OPK_STRING_COPY,
				i[2] ? 8'h09 : 8'h07);
			`CHK("copy src", sz, op.src_size)
			`CHK("copy dst", sz, op.dst_size)
		end
	endtask : t_string
	// sign and zero extend, reg and memory, hit and miss
	task automatic t_extend;
		logic [7:0] c;
		for (int i = 0; i < 16; i++) begin
			c = (i[2] && i[3]) ? 8'h05 : ((i[0] || i[2]) ? 8'h03 : 8'h02);
			run_op('{8'h0F, {i[0] ? 7'h5B : 7'h5F, i[1]}, i[2] ? 8'h08 : 8'hCA}, 3,
				i[3] ^ i[1], i[3], i[0] ? OPK_ZERO_EXTEND : OPK_SIGN_EXTEND, c);
			`CHK("ext src", i[1] ? SIZE_WORD : SIZE_BYTE, op.src_size)
			`CHK("ext dst", (i[3] ^ i[1]) ? SIZE_DWORD : SIZE_WORD, op.dst_size)
			`CHK("ext mem", i[2], op.mem_source)
			`CHK("ext reg", 3'h1, op.gen_reg)
			`CHK("ext rm", i[2] ? 3'h0 : 3'h2, op.rm_reg)
		end
	endtask : t_extend
	initial begin
		reset_n     = 1'b0;
		operand_32  = 1'b0;
		cache_miss  = 1'b0;
		bad_count   = 0;
		checks_done = 0;
		cycles      = 0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_debug();
		t_test();
		t_string();
		t_extend();
		run_op('{8'h90, 8'h00, 8'h00}, 1, 1'b0, 1'b0, OPK_INVALID, 8'h00);
		run_op('{8'h0F, 8'h22, 8'h00}, 2, 1'b0, 1'b0, OPK_INVALID, 8'h00);
		test_done();
	end
endmodule : move_instruction_decode_test
`default_nettype wire
